// File: core/dosel_output_select.v
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dosel_regs.vh"
module dosel_output_select #(
    parameter TICK_CYC = `DOSEL_TICK_CYC, // cycles per 100 ms
    parameter LINK_TO_TICK = `DOSEL_LINK_TO_TICK // link timeout ticks
) (
    input wire mclk,
    input wire resetn,
    // register port
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata,
    // drive state from same clock domain
    input wire [15:0] setFreq, // commanded frequency, 0.01 Hz
    input wire [15:0] runFreq, // actual output frequency, 0.01 Hz
    input wire accelerating,
    input wire decelerating,
    input wire constSpeed,
    input wire runCmd,
    input wire outVoltNonzero,
    input wire motorOverloadFlag,
    input wire driveOverloadFlag,
    input wire stallFlag,
    input wire overVoltTrip,
    input wire lowVoltTrip,
    input wire heatsinkHotFlag,
    input wire analogLoss,
    input wire serialLoss,
    input wire speedSearch,
    input wire runWait,
    input wire otherTrip, // any trip besides low voltage
    input wire fanFault,
    input wire restartPending, // auto restart count in use
    input wire keypadLinkOk, // comm good strobe/level from keypad link
    // contacts
    output reg transistorOutput,
    output reg relayOutput
);
    // -----------------------------------------------------------
    // reset release
    // -----------------------------------------------------------
    reg rstSync1_r;
    reg rstSync2_r;
    wire rstn;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstn = rstSync2_r;

    // -----------------------------------------------------------
    // settings
    // -----------------------------------------------------------
    reg [15:0] detectLevel_r; // detect_level_setting
    reg [15:0] detectBand_r; // detect_bandwidth_setting
    reg [15:0] maxFreq_r; // max_frequency_setting
    reg [4:0] trSel_r; // transistor_source_select
    reg [4:0] rlSel_r; // relay_source_select
    reg [2:0] faultMask_r; // fault_mask_setting
    reg [1:0] linkRoute_r; // link_error_routing
    reg polarity_r; // contact_polarity_select
    reg [6:0] trOn_r; // delays in 0.1 s units
    reg [6:0] trOff_r;
    reg [6:0] rlOn_r;
    reg [6:0] rlOff_r;
    reg fanPolicy_r; // fan_fault_policy, 0 keeps running
    reg rejected_r; // last write refused, sticky until next write

    wire running;
    wire freqOk;
    wire delayOk;
    assign running = runCmd | outVoltNonzero;
    // frequency writes above the cap or the top are refused
    assign freqOk = (regWdata <= `DOSEL_FREQ_LIMIT) &&
                    (regWdata <= maxFreq_r);
    // delays are refused above 10 s or while running
    assign delayOk = (regWdata <= {9'h000, `DOSEL_DELAY_LIMIT}) &&
                     !running;

    // settings writes; one write per strobe
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            detectLevel_r <= `DOSEL_RST_LEVEL;
            detectBand_r <= `DOSEL_RST_BAND;
            maxFreq_r <= `DOSEL_RST_MAXF;
            trSel_r <= `DOSEL_RST_TRSEL;
            rlSel_r <= `DOSEL_RST_RLSEL;
            faultMask_r <= `DOSEL_RST_FMASK;
            linkRoute_r <= 2'h0;
            polarity_r <= 1'b0;
            trOn_r <= 7'h00;
            trOff_r <= 7'h00;
            rlOn_r <= 7'h00;
            rlOff_r <= 7'h00;
            fanPolicy_r <= 1'b0;
            rejected_r <= 1'b0;
        end else if (regWr) begin
            rejected_r <= 1'b0;
            case (regAddr)
                `DOSEL_A_LEVEL: begin
                    if (freqOk) detectLevel_r <= regWdata;
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_BAND: begin
                    if (freqOk) detectBand_r <= regWdata;
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_MAXF: begin
                    if (regWdata <= `DOSEL_FREQ_LIMIT) maxFreq_r <= regWdata;
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_TRSEL: begin
                    if (regWdata <= 16'h0012) trSel_r <= regWdata[4:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_RLSEL: begin
                    if (regWdata <= 16'h0012) rlSel_r <= regWdata[4:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_FMASK: faultMask_r <= regWdata[2:0];
                `DOSEL_A_ROUTE: begin
                    if (regWdata <= 16'h0003) linkRoute_r <= regWdata[1:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_POL: polarity_r <= regWdata[0];
                `DOSEL_A_FANPOL: fanPolicy_r <= regWdata[0];
                `DOSEL_A_TRON: begin
                    if (delayOk) trOn_r <= regWdata[6:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_TROFF: begin
                    if (delayOk) trOff_r <= regWdata[6:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_RLON: begin
                    if (delayOk) rlOn_r <= regWdata[6:0];
                    else rejected_r <= 1'b1;
                end
                `DOSEL_A_RLOFF: begin
                    if (delayOk) rlOff_r <= regWdata[6:0];
                    else rejected_r <= 1'b1;
                end
                default: rejected_r <= 1'b1; // unmapped or read-only
            endcase
        end
    end

    // -----------------------------------------------------------
    // frequency detection
    // -----------------------------------------------------------
    // absolute difference, used for detect 1 and detect 3
    function [15:0] absDiff;
        input [15:0] a;
        input [15:0] b;
        begin
            absDiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    wire [15:0] halfBand;
    wire [15:0] lowEdge;
    wire det1;
    wire det2;
    wire det3;
    reg det4_r; // hysteresis state
    assign halfBand = {1'b0, detectBand_r[15:1]};
    assign lowEdge = (detectLevel_r > halfBand) ?
                     (detectLevel_r - halfBand) : 16'h0000;
    assign det1 = absDiff(setFreq, runFreq) <= halfBand;
    assign det2 = (setFreq == detectLevel_r) && det1;
    assign det3 = absDiff(detectLevel_r, runFreq) <= halfBand;

    // detect 4: set at level unless decelerating, held above low edge
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            det4_r <= 1'b0;
        end else if (runFreq >= detectLevel_r && !decelerating) begin
            det4_r <= 1'b1;
        end else if (runFreq <= lowEdge) begin
            det4_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------
    // keypad link watchdog
    // -----------------------------------------------------------
    reg linkSync1_r;
    reg linkSync2_r;
    reg [15:0] linkCnt_r; // ticks without good comm
    reg linkErr_r;
    reg [31:0] tickCnt_r;
    reg tick_r; // one-cycle 100 ms enable
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            linkSync1_r <= 1'b0;
            linkSync2_r <= 1'b0;
        end else begin
            linkSync1_r <= keypadLinkOk;
            linkSync2_r <= linkSync1_r;
        end
    end

    // 100 ms tick divider for the delays and the watchdog
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (tickCnt_r >= TICK_CYC - 1) begin
            tickCnt_r <= 32'h00000000;
            tick_r <= 1'b1;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h00000001;
            tick_r <= 1'b0;
        end
    end

    // error only after a continuous failure of the fixed timeout
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            linkCnt_r <= 16'h0000;
            linkErr_r <= 1'b0;
        end else if (linkSync2_r) begin
            linkCnt_r <= 16'h0000;
            linkErr_r <= 1'b0;
        end else if (linkCnt_r >= LINK_TO_TICK) begin
            linkErr_r <= 1'b1;
        end else if (tick_r) begin
            linkCnt_r <= linkCnt_r + 16'h0001;
        end
    end

    // -----------------------------------------------------------
    // source selection
    // -----------------------------------------------------------
    wire faultOut;
    // bit0 low voltage, bit1 other trips, bit2 while restarting
    assign faultOut = (faultMask_r[0] & lowVoltTrip) |
                      (faultMask_r[1] & otherTrip) |
                      (faultMask_r[2] & restartPending &
                       (lowVoltTrip | otherTrip));

    // one selector serves both contacts
    function pickSource;
        input [4:0] sel;
        begin
            case (sel)
                5'h00: pickSource = det1;
                5'h01: pickSource = det2;
                5'h02: pickSource = det3;
                5'h03: pickSource = det4_r;
                5'h04: pickSource = ~det4_r;
                5'h05: pickSource = motorOverloadFlag;
                5'h06: pickSource = driveOverloadFlag;
                5'h07: pickSource = stallFlag;
                5'h08: pickSource = overVoltTrip;
                5'h09: pickSource = lowVoltTrip;
                5'h0A: pickSource = heatsinkHotFlag;
                5'h0B: pickSource = analogLoss | serialLoss;
                5'h0C: pickSource = runCmd & outVoltNonzero;
                5'h0D: pickSource = ~runCmd & ~outVoltNonzero &
                                    (runFreq == 16'h0000);
                5'h0E: pickSource = constSpeed;
                5'h0F: pickSource = speedSearch;
                5'h10: pickSource = runWait;
                5'h11: pickSource = faultOut;
                5'h12: pickSource = fanFault & ~fanPolicy_r;
                default: pickSource = 1'b0;
            endcase
        end
    endfunction

    wire trRaw;
    wire rlRaw;
    wire trDelayed;
    wire rlDelayed;
    assign trRaw = pickSource(trSel_r) | (linkRoute_r[0] & linkErr_r);
    assign rlRaw = pickSource(rlSel_r) | (linkRoute_r[1] & linkErr_r);
    // link error routing above

    dosel_delay u_trDelay (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick_r),
        .din(trRaw),
        .onDelay(trOn_r),
        .offDelay(trOff_r),
        .dout(trDelayed)
    );

    dosel_delay u_rlDelay (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick_r),
        .din(rlRaw),
        .onDelay(rlOn_r),
        .offDelay(rlOff_r),
        .dout(rlDelayed)
    );

    // -----------------------------------------------------------
    // outputs and read port
    // -----------------------------------------------------------
    // polarity applies to the transistor only; relay has both contacts
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            transistorOutput <= 1'b0;
            relayOutput <= 1'b0;
        end else begin
            transistorOutput <= trDelayed ^ polarity_r;
            relayOutput <= rlDelayed;
        end
    end

    // read data appear the cycle after the strobe only
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `DOSEL_A_LEVEL: regRdata <= detectLevel_r;
                `DOSEL_A_BAND: regRdata <= detectBand_r;
                `DOSEL_A_TRSEL: regRdata <= {11'h000, trSel_r};
                `DOSEL_A_RLSEL: regRdata <= {11'h000, rlSel_r};
                `DOSEL_A_FMASK: regRdata <= {13'h0000, faultMask_r};
                `DOSEL_A_ROUTE: regRdata <= {14'h0000, linkRoute_r};
                `DOSEL_A_POL: regRdata <= {15'h0000, polarity_r};
                `DOSEL_A_TRON: regRdata <= {9'h000, trOn_r};
                `DOSEL_A_TROFF: regRdata <= {9'h000, trOff_r};
                `DOSEL_A_RLON: regRdata <= {9'h000, rlOn_r};
                `DOSEL_A_RLOFF: regRdata <= {9'h000, rlOff_r};
                `DOSEL_A_MAXF: regRdata <= maxFreq_r;
                `DOSEL_A_FANPOL: regRdata <= {15'h0000, fanPolicy_r};
                `DOSEL_A_STATUS: regRdata <= {9'h000, rejected_r,
                    linkErr_r, det4_r, det3, det1, rlDelayed, trDelayed};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end
endmodule // dosel_output_select
`default_nettype wire

// File: shared/dosel_regs.vh
`ifndef DOSEL_REGS_VH
`define DOSEL_REGS_VH
// register indices (word addresses on the plain port)
`define DOSEL_A_LEVEL      4'h0
`define DOSEL_A_BAND       4'h1
`define DOSEL_A_TRSEL      4'h2
`define DOSEL_A_RLSEL      4'h3
`define DOSEL_A_FMASK      4'h4
`define DOSEL_A_ROUTE      4'h5
`define DOSEL_A_POL        4'h6
`define DOSEL_A_TRON       4'h7
`define DOSEL_A_TROFF      4'h8
`define DOSEL_A_RLON       4'h9
`define DOSEL_A_RLOFF      4'hA
`define DOSEL_A_MAXF       4'hB
`define DOSEL_A_FANPOL     4'hC
`define DOSEL_A_STATUS     4'hD
// reset values, frequency in 0.01 Hz
`define DOSEL_RST_LEVEL    16'h0BB8
`define DOSEL_RST_BAND     16'h03E8
`define DOSEL_RST_MAXF     16'h1770
`define DOSEL_RST_TRSEL    5'h0C
`define DOSEL_RST_RLSEL    5'h11
`define DOSEL_RST_FMASK    3'h2
`define DOSEL_FREQ_LIMIT   16'h9C40
`define DOSEL_DELAY_LIMIT  7'h64
// selection codes
`define DOSEL_SEL_FAULT    5'h11
// timing: 100 ms tick at 100 MHz, link timeout in ms
`define DOSEL_TICK_NS      100000000
`define DOSEL_CLK_NS       10
`define DOSEL_TICK_CYC     (`DOSEL_TICK_NS / `DOSEL_CLK_NS)
`define DOSEL_LINK_TO_MS   1000
`define DOSEL_LINK_TO_TICK (`DOSEL_LINK_TO_MS / 100)
`endif

// File: core/dosel_delay.v
`timescale 1ns/1ns
`default_nettype none
// on/off delay filter for one contact; tick is a 100 ms enable
module dosel_delay (
    input wire mclk,
    input wire rstn,
    input wire tick,
    input wire din,
    input wire [6:0] onDelay,
    input wire [6:0] offDelay,
    output reg dout
);
    reg [6:0] cnt_r; // ticks spent with din differing from dout

    // -----------------------------------------------------------
    // filter
    // -----------------------------------------------------------
    // a pulse shorter than its delay restarts the count and is lost
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dout <= 1'b0;
            cnt_r <= 7'h00;
        end else if (din == dout) begin
            cnt_r <= 7'h00;
        end else if ((din ? onDelay : offDelay) <= cnt_r) begin
            dout <= din;
            cnt_r <= 7'h00;
        end else if (tick) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end
endmodule // dosel_delay
`default_nettype wire

// File: testbench/dosel_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// --------------
// keypad link and contact loads
// --------------
module dosel_far_side (
    input wire logic mclk,
    input wire logic linkFail, // bench asks for a dead keypad link
    input wire logic transistorOutput,
    input wire logic relayOutput,
    output logic keypadLinkOk,
    output logic [15:0] trOnCycles, // cycles transistor load energised
    output logic [15:0] rlOnCycles // cycles relay coil energised
);
    // keypad answers every poll unless the bench kills it
    assign keypadLinkOk = !linkFail;
    initial begin
        trOnCycles = 16'h0000;
        rlOnCycles = 16'h0000;
    end
    // loads only see levels, so a glitch shows up as a count step
    always @(posedge mclk) begin
        trOnCycles <= trOnCycles + {15'h0000, transistorOutput};
        rlOnCycles <= rlOnCycles + {15'h0000, relayOutput};
    end
endmodule // dosel_far_side
`default_nettype wire

// File: testbench/dosel_output_select_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "dosel_regs.vh"
module dosel_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic runCmd,
    input wire logic outVoltNonzero,
    input wire logic overVoltTrip,
    input wire logic otherTrip,
    input wire logic heatsinkHotFlag,
    input wire logic transistorOutput,
    input wire logic relayOutput
);
    // --------------
    // shadow of the settings
    // --------------
    reg [4:0] trSel_r; // transistor source select
    reg [4:0] rlSel_r; // relay source select
    reg [2:0] mask_r; // fault mask
    reg pol_r; // contact polarity
    reg [4:0] busy_r; // nonzero routing and delays
    wire running = runCmd | outVoltNonzero;
    wire quiet = (busy_r == 5'h00); // no delay, no link routing
    // follows accepted writes only
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trSel_r <= 5'h0C;
            rlSel_r <= 5'h11;
            mask_r <= 3'h2;
            pol_r <= 1'b0;
            busy_r <= 5'h00;
        end else if (regWr) begin
            if (regAddr == `DOSEL_A_TRSEL && regWdata <= 16'h0012)
                trSel_r <= regWdata[4:0];
            if (regAddr == `DOSEL_A_RLSEL && regWdata <= 16'h0012)
                rlSel_r <= regWdata[4:0];
            if (regAddr == `DOSEL_A_FMASK) mask_r <= regWdata[2:0];
            if (regAddr == `DOSEL_A_POL) pol_r <= regWdata[0];
            if (regAddr == `DOSEL_A_ROUTE && regWdata <= 16'h0003)
                busy_r[0] <= |regWdata;
            if (regAddr >= `DOSEL_A_TRON && regAddr <= `DOSEL_A_RLOFF
                && regWdata <= 16'h0064 && !running)
                busy_r[regAddr - 4'h6] <= |regWdata;
        end
    end
    // --------------
    // assertions
    // --------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    run_follow_a: assert property (
        (quiet && trSel_r == 5'h0C && !pol_r && runCmd && outVoltNonzero)
        [*4] |-> transistorOutput) else $error("run state not shown");
    rise_cause_a: assert property (
        (quiet && trSel_r == 5'h0C && !pol_r) [*3] ##0 $rose(transistorOutput)
        |-> $past(runCmd && outVoltNonzero, 2))
        else $error("output rose without run state");
    pol_invert_a: assert property (
        (quiet && trSel_r == 5'h0C && pol_r && runCmd && outVoltNonzero)
        [*4] |-> !transistorOutput) else $error("polarity not applied");
    relay_nopol_a: assert property (
        (quiet && rlSel_r == 5'h0C && pol_r && runCmd && outVoltNonzero)
        [*4] |-> relayOutput) else $error("relay took polarity");
    ov_follow_a: assert property (
        (quiet && trSel_r == 5'h08 && !pol_r) [*3]
        |-> transistorOutput == $past(overVoltTrip, 2))
        else $error("over-voltage not followed");
    fault_mask_a: assert property (
        (quiet && rlSel_r == 5'h11 && mask_r == 3'h2) [*3]
        |-> relayOutput == $past(otherTrip, 2))
        else $error("fault mask 2 wrong");
    heat_follow_a: assert property (
        (quiet && rlSel_r == 5'h0A) [*3]
        |-> relayOutput == $past(heatsinkHotFlag, 2))
        else $error("heatsink flag not followed");
    out_reset_a: assert property (
        $rose(resetn) |-> (!transistorOutput && !relayOutput) [*2])
        else $error("contacts active out of reset");
    cover property (trSel_r == 5'h03 && transistorOutput);
    cover property (!quiet && transistorOutput && relayOutput);
    cover property (pol_r && !transistorOutput && relayOutput);
endmodule // dosel_chk
bind dosel_output_select dosel_chk dosel_chk_i (.*);
`default_nettype wire

// File: testbench/dosel_output_select_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "dosel_regs.vh"
module dosel_output_select_test;
    // --------------
    // stimulus and harness
    // --------------
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] setFreq = 16'h0000;
    logic [15:0] runFreq = 16'h0000;
    logic [17:0] fl = 18'h00000; // one bit per drive state input
    logic linkFail = 1'b0;
    wire logic [15:0] regRdata;
    wire logic transistorOutput, relayOutput, keypadLinkOk;
    wire logic [15:0] trOnCycles, rlOnCycles;
    int n_fail = 0, n_compared = 0, cycles = 0, i, c, k, s, r, n;
    logic [15:0] rv, t0, r0;
    logic [1:0] m;
    logic fp;
    logic [15:0] rst[13] = '{16'h0BB8, 16'h03E8, 16'h000C, 16'h0011,
        16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h1770, 16'h0000};
    int hf[6] = '{2999, 3000, 2600, 2501, 2500, 2800}; // detect 4 walk
    logic he[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    always #5 mclk = ~mclk;
    dosel_output_select #(.TICK_CYC(10), .LINK_TO_TICK(2))
    dosel_output_select_i (.*, .accelerating(fl[0]), .decelerating(fl[1]),
        .constSpeed(fl[2]), .runCmd(fl[3]), .outVoltNonzero(fl[4]),
        .motorOverloadFlag(fl[5]), .driveOverloadFlag(fl[6]),
        .stallFlag(fl[7]), .overVoltTrip(fl[8]), .lowVoltTrip(fl[9]),
        .heatsinkHotFlag(fl[10]), .analogLoss(fl[11]),
        .serialLoss(fl[12]), .speedSearch(fl[13]), .runWait(fl[14]),
        .otherTrip(fl[15]), .fanFault(fl[16]), .restartPending(fl[17]));
    dosel_far_side dosel_far_side_i (.*);
    // --------------
    // bus, compare and expectation helpers
    // --------------
    task automatic cyc(input int q);
        repeat (q) @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        d = regRdata;
        @(posedge mclk);
    endtask
    task automatic cmpBit(input string nm, input logic e, input logic g);
        cmpWord(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic cmpWord(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write that must bounce: flag raised, old value kept
    task automatic chkRej(input logic [3:0] a, input logic [15:0] d,
        input logic [15:0] e);
        logic [15:0] q;
        wr(a, d);
        rd(`DOSEL_A_STATUS, q);
        cmpBit("reject flag", 1'b1, q[6]);
        rd(a, q);
        cmpWord("refused write", e, q);
    endtask
    // source level for a stateless code with default level and band
    function automatic logic srcOf(input int q, input logic p,
        input logic [1:0] mk);
        int hb, d1, d3;
        hb = `DOSEL_RST_BAND / 2;
        d1 = (s - r <= hb) && (r - s <= hb);
        d3 = (3000 - r <= hb) && (r - 3000 <= hb);
        case (q)
            0: return d1 != 0;
            1: return d1 != 0 && s == 3000;
            2: return d3 != 0;
            5, 6, 7, 8, 9, 10: return fl[q];
            11: return fl[11] | fl[12];
            12: return fl[3] & fl[4];
            13: return !fl[3] && !fl[4] && r == 0;
            14: return fl[2];
            15: return fl[13];
            16: return fl[14];
            17: return (mk[0] & fl[9]) | (mk[1] & fl[15]);
            default: return fl[16] & !p;
        endcase
    endfunction
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard, well above run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report;
        end
    end
    // --------------
    // scenarios
    // --------------
    initial begin
        void'($urandom(33));
        cyc(5);
        resetn <= 1'b1;
        cyc(3);
        for (i = 0; i < 13; i++) begin
            rd(i[3:0], rv);
            cmpWord("reset value", rst[i], rv);
        end
        chkRej(`DOSEL_A_BAND, 16'h1771, 16'h03E8);
        chkRej(`DOSEL_A_LEVEL, 16'h9C41, 16'h0BB8);
        chkRej(`DOSEL_A_TRON, 16'h0065, 16'h0000);
        chkRej(`DOSEL_A_RLOFF, 16'h0065, 16'h0000);
        chkRej(`DOSEL_A_ROUTE, 16'h0004, 16'h0000);
        wr(`DOSEL_A_BAND, 16'h1770);
        rd(`DOSEL_A_BAND, rv);
        cmpWord("band at max", 16'h1770, rv);
        wr(`DOSEL_A_BAND, 16'h03E8);
        // random sources and selects, delays zero
        for (i = 0; i < 150; i++) begin
            c = $urandom % 17;
            k = $urandom % 17;
            c = (c > 2) ? c + 2 : c;
            k = (k > 2) ? k + 2 : k;
            m = 2'($urandom);
            fp = 1'($urandom);
            fl <= 18'h00000;
            cyc(1);
            wr(`DOSEL_A_TRSEL, c[15:0]);
            wr(`DOSEL_A_RLSEL, k[15:0]);
            wr(`DOSEL_A_FMASK, {14'h0000, m});
            wr(`DOSEL_A_FANPOL, {15'h0000, fp});
            s = ($urandom % 4 == 0) ? 3000 : $urandom % 6000;
            r = s + $urandom % 1200 - 600;
            r = (r < 0 || $urandom % 5 == 0) ? 0 : r;
            setFreq <= s[15:0];
            runFreq <= r[15:0];
            fl <= {1'b0, 17'($urandom)};
            cyc(4);
            cmpBit("transistor src", srcOf(c, fp, m), transistorOutput);
            cmpBit("relay src", srcOf(k, fp, m), relayOutput);
        end
        fl <= 18'h00000;
        runFreq <= 16'h0000; // clears detect 4 state left by random runs
        cyc(1);
        wr(`DOSEL_A_TRSEL, 16'h0003);
        wr(`DOSEL_A_RLSEL, 16'h0004);
        for (i = 0; i < 6; i++) begin
            runFreq <= hf[i][15:0];
            fl[1:0] <= (i < 2) ? 2'b01 : 2'b10;
            cyc(4);
            cmpBit("detect4", he[i], transistorOutput);
            cmpBit("detect5", !he[i], relayOutput);
        end
        fl <= 18'h00000;
        wr(`DOSEL_A_TRSEL, 16'h000C);
        wr(`DOSEL_A_RLSEL, 16'h000C);
        wr(`DOSEL_A_POL, 16'h0001);
        for (i = 0; i < 2; i++) begin
            fl[4:3] <= {2{i[0]}};
            cyc(4);
            cmpBit("inverted contact", !i[0], transistorOutput);
            cmpBit("relay polarity", i[0], relayOutput);
        end
        fl <= 18'h00000;
        wr(`DOSEL_A_POL, 16'h0000);
        for (i = 7; i < 11; i++) wr(i[3:0], 16'h0002);
        t0 = trOnCycles;
        r0 = rlOnCycles;
        fl[4:3] <= 2'b11;
        cyc(8);
        fl[4:3] <= 2'b00;
        cyc(40);
        cmpWord("short on pulse", t0, trOnCycles);
        cmpWord("short relay pulse", r0, rlOnCycles);
        fl[4:3] <= 2'b11;
        for (n = 0; transistorOutput !== 1'b1 && n < 60; n++) cyc(1);
        cyc(2);
        cmpBit("on delay span", 1'b1, n >= 12 && n <= 34);
        cmpBit("relay on delay", 1'b1, relayOutput);
        wr(`DOSEL_A_TRON, 16'h0000);
        rd(`DOSEL_A_STATUS, rv);
        cmpBit("locked while running", 1'b1, rv[6]);
        rd(`DOSEL_A_TRON, rv);
        cmpWord("on delay kept", 16'h0002, rv);
        t0 = trOnCycles;
        r0 = rlOnCycles;
        fl[4:3] <= 2'b00;
        cyc(8);
        fl[4:3] <= 2'b11;
        cyc(40);
        cmpWord("short off gap", t0 + 16'h0030, trOnCycles);
        cmpWord("relay off gap", r0 + 16'h0030, rlOnCycles);
        fl[4:3] <= 2'b00;
        for (n = 0; transistorOutput !== 1'b0 && n < 60; n++) cyc(1);
        cmpBit("off delay span", 1'b1, n >= 12 && n <= 34);
        for (i = 7; i < 11; i++) wr(i[3:0], 16'h0000);
        wr(`DOSEL_A_TRSEL, 16'h000A);
        wr(`DOSEL_A_RLSEL, 16'h000A);
        for (i = 1; i < 4; i++) begin
            wr(`DOSEL_A_ROUTE, i[15:0]);
            linkFail <= 1'b1;
            cyc(8);
            cmpBit("link early", 1'b0, transistorOutput | relayOutput);
            cyc(50);
            cmpBit("link to transistor", i[0], transistorOutput);
            cmpBit("link to relay", i[1], relayOutput);
            linkFail <= 1'b0;
            cyc(20);
            cmpBit("link back", 1'b0, transistorOutput | relayOutput);
        end
        wr(`DOSEL_A_ROUTE, 16'h0000);
        final_report;
    end
endmodule // dosel_output_select_test
`default_nettype wire
